// file: rtl/pmcmd_pkg.sv
// Constants shared by the power manager command port
package pmcmd_pkg;
    // Register map location of the command port
    localparam logic [15:0] PMCMD_CMD_ADDR    = 16'h8000;
    // Opcodes of the command port; the reserved code 00h starts no action
    localparam logic [7:0]  PMCMD_OP_RESERVED = 8'h00;
    localparam logic [7:0]  PMCMD_OP_POWER_ON = 8'h01;
    localparam logic [7:0]  PMCMD_OP_POWER_OFF = 8'h02;
    localparam logic [7:0]  PMCMD_OP_MARGIN_LO = 8'h03;
    localparam logic [7:0]  PMCMD_OP_MARGIN_NOMINAL_COMMAND = 8'h04;
    // Regulator bus OPERATION command code
    localparam logic [7:0]  PMCMD_PMBUS_OPERATION = 8'h01;
    // Engine state encoding
    localparam logic [1:0]  PMCMD_ENG_STOPPED  = 2'h0;
    localparam logic [1:0]  PMCMD_ENG_STARTING = 2'h1;
    localparam logic [1:0]  PMCMD_ENG_STARTED  = 2'h2;
    localparam logic [1:0]  PMCMD_ENG_STOPPING = 2'h3;
    // Transfer limits: address bytes, opcode, parameter bytes
    localparam logic [6:0]  PMCMD_MAX_PARAMS  = 7'h3F;
    localparam logic [6:0]  PMCMD_IDX_ADDR_LO = 7'h01;
    localparam logic [6:0]  PMCMD_IDX_OPCODE  = 7'h02;
    localparam logic [6:0]  PMCMD_IDX_PARAM0  = 7'h03;
    localparam logic [6:0]  PMCMD_IDX_LAST    = 7'h41;
    localparam logic [3:0]  PMCMD_BITS_BYTE   = 4'h8;
    // Channel range
    localparam logic [7:0]  PMCMD_CHAN_MIN    = 8'h01;
    localparam logic [7:0]  PMCMD_CHAN_MAX    = 8'h40;
    // Closed-loop trim step period
    localparam int          PMCMD_CLK_PERIOD_NS = 5;
    localparam int          PMCMD_TRIM_STEP_NS  = 1000;
    localparam int          PMCMD_TRIM_STEP_CYC =
        PMCMD_TRIM_STEP_NS / PMCMD_CLK_PERIOD_NS;
    // Serial target states
    typedef enum logic [2:0] {
        PMCMD_ST_IDLE,
        PMCMD_ST_ADDR,
        PMCMD_ST_ADDR_ACK,
        PMCMD_ST_DATA,
        PMCMD_ST_DATA_ACK
    } pmcmd_state_t;
endpackage

// file: rtl/pmcmd_port.sv
// Write-only I2C command port of a multi-rail power manager
module pmcmd_port
    import pmcmd_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h10,
    parameter int          DAC_W    = 10,
    parameter int          ADC_W    = 12,
    parameter int          STEP_CYC = PMCMD_TRIM_STEP_CYC
)(
    input  wire logic             i_mclk,
    input  wire logic             i_arst_n,
    input  wire logic             i_scl,
    input  wire logic             i_sda,
    output logic                  o_sda,
    output logic                  o_sda_oe,
    input  wire logic [1:0]       i_engine_state,
    input  wire logic [63:0]      i_digital_regulator_channel,
    input  wire logic [63:0]      i_closed_loop,
    input  wire logic [DAC_W-1:0] i_low_margin_dac_setting,
    input  wire logic [DAC_W-1:0] i_nominal_dac_setting,
    input  wire logic [ADC_W-1:0] i_low_trim_target,
    input  wire logic [ADC_W-1:0] i_nominal_voltage_target,
    input  wire logic [ADC_W-1:0] i_meas_voltage,
    output logic                  o_power_on_req,
    output logic                  o_power_off_req,
    output logic [63:0]           o_margin_low,
    output logic [5:0]            o_trim_chan,
    output logic [DAC_W-1:0]      o_trim_dac,
    output logic                  o_trim_load,
    output logic                  o_trim_busy,
    output logic                  o_pmbus_req,
    output logic [5:0]            o_pmbus_chan,
    output logic [7:0]            o_pmbus_cmd,
    output logic                  o_pmbus_margin_low
);

    // Refuse parameter values the logic cannot serve
    if (DAC_W < 2 || DAC_W > 16 || ADC_W < 2 || ADC_W > 16 ||
        STEP_CYC < 1 || STEP_CYC > 65535)
    begin : g_param_check
        $error("pmcmd_port: unsupported parameter value");
    end

    // Map a channel number 1..64 to its bit index
    function automatic logic [5:0] chan_index(input logic [7:0] chan);
        logic [7:0] idx;
        idx = chan - PMCMD_CHAN_MIN;
        return idx[5:0];
    endfunction

    // Two-stage synchronisers for the serial pins, plus history stage
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic       scl_prev_reg;
    logic       sda_prev_reg;
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    // Bus events seen on the synchronised lines
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise  = scl_sync_reg[1] && !scl_prev_reg;
    assign scl_fall  = !scl_sync_reg[1] && scl_prev_reg;
    assign bus_start = scl_sync_reg[1] && scl_prev_reg &&
                       !sda_sync_reg[1] && sda_prev_reg;
    assign bus_stop  = scl_sync_reg[1] && scl_prev_reg &&
                       sda_sync_reg[1] && !sda_prev_reg;

    // Serial target state and received transfer
    pmcmd_state_t state_reg;
    logic [3:0]   bit_cnt_reg;
    logic [7:0]   shift_reg;
    logic [6:0]   byte_idx_reg;
    logic [15:0]  reg_addr_reg;
    logic [7:0]   opcode_reg;
    logic [7:0]   param_reg;
    logic         exec_pulse;
    logic [7:0]   rx_byte;
    assign rx_byte = shift_reg;

    // Target state machine: address match, acknowledge, byte capture
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg    <= PMCMD_ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            byte_idx_reg <= 7'h00;
            reg_addr_reg <= 16'h0000;
            opcode_reg   <= PMCMD_OP_RESERVED;
            param_reg    <= 8'h00;
            o_sda        <= 1'b0;
            o_sda_oe     <= 1'b0;
            exec_pulse   <= 1'b0;
        end
        else
        begin
            exec_pulse <= 1'b0;
            if (bus_start)
            begin
                state_reg    <= PMCMD_ST_ADDR;
                bit_cnt_reg  <= 4'h0;
                byte_idx_reg <= 7'h00;
                o_sda_oe     <= 1'b0;
            end
            else if (bus_stop)
            begin
                // Command acts once the whole transfer has closed
                exec_pulse <= (state_reg == PMCMD_ST_DATA) &&
                              (byte_idx_reg > PMCMD_IDX_OPCODE);
                state_reg  <= PMCMD_ST_IDLE;
                o_sda_oe   <= 1'b0;
            end
            else
            begin
                unique case (state_reg)
                    PMCMD_ST_IDLE:
                    begin
                        o_sda_oe <= 1'b0;
                    end
                    PMCMD_ST_ADDR,
                    PMCMD_ST_DATA:
                    begin
                        if (scl_rise && bit_cnt_reg < PMCMD_BITS_BYTE)
                        begin
                            shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_reg == PMCMD_BITS_BYTE)
                        begin
                            bit_cnt_reg <= 4'h0;
                            if (state_reg == PMCMD_ST_ADDR)
                            begin
                                // Write-only: reads and foreign ids are not acked
                                if (rx_byte == {DEV_ADDR, 1'b0})
                                begin
                                    o_sda_oe  <= 1'b1;
                                    state_reg <= PMCMD_ST_ADDR_ACK;
                                end
                                else
                                    state_reg <= PMCMD_ST_IDLE;
                            end
                            else if (byte_idx_reg <= PMCMD_IDX_LAST)
                            begin
                                // Opcode plus at most 63 parameters accepted
                                if (byte_idx_reg == 7'h00)
                                    reg_addr_reg[15:8] <= rx_byte;
                                if (byte_idx_reg == PMCMD_IDX_ADDR_LO)
                                    reg_addr_reg[7:0] <= rx_byte;
                                if (byte_idx_reg == PMCMD_IDX_OPCODE)
                                    opcode_reg <= rx_byte;
                                if (byte_idx_reg == PMCMD_IDX_PARAM0)
                                    param_reg <= rx_byte;
                                byte_idx_reg <= byte_idx_reg + 7'h01;
                                o_sda_oe     <= 1'b1;
                                state_reg    <= PMCMD_ST_DATA_ACK;
                            end
                            else
                                state_reg <= PMCMD_ST_IDLE;
                        end
                    end
                    PMCMD_ST_ADDR_ACK,
                    PMCMD_ST_DATA_ACK:
                    begin
                        // Release the data line after the acknowledge clock
                        if (scl_fall)
                        begin
                            o_sda_oe  <= 1'b0;
                            state_reg <= PMCMD_ST_DATA;
                        end
                    end
                endcase
            end
        end
    end

    // Command decode on the completed transfer
    logic       at_cmd_addr;
    logic       engine_started;
    logic       margin_op;
    logic       chan_ok;
    logic       margin_go;
    logic [5:0] chan_idx;
    assign at_cmd_addr    = (reg_addr_reg == PMCMD_CMD_ADDR);
    assign engine_started = (i_engine_state == PMCMD_ENG_STARTED);
    assign margin_op      = (opcode_reg == PMCMD_OP_MARGIN_LO) ||
                            (opcode_reg == PMCMD_OP_MARGIN_NOMINAL_COMMAND);
    assign chan_ok        = (byte_idx_reg > PMCMD_IDX_PARAM0) &&
                            (param_reg >= PMCMD_CHAN_MIN) &&
                            (param_reg <= PMCMD_CHAN_MAX);
    assign margin_go      = exec_pulse && at_cmd_addr && margin_op &&
                            engine_started && chan_ok;
    assign chan_idx       = chan_index(param_reg);

    // Sequencing requests; other opcodes fall through with no action
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_power_on_req  <= 1'b0;
            o_power_off_req <= 1'b0;
        end
        else
        begin
            o_power_on_req  <= exec_pulse && at_cmd_addr &&
                               opcode_reg == PMCMD_OP_POWER_ON &&
                               i_engine_state == PMCMD_ENG_STOPPED;
            o_power_off_req <= exec_pulse && at_cmd_addr &&
                               opcode_reg == PMCMD_OP_POWER_OFF &&
                               engine_started;
        end
    end

    // Per-channel margin level, nominal after reset
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_margin_low <= 64'h0000_0000_0000_0000;
        else if (margin_go)
            o_margin_low[chan_idx] <=
                (opcode_reg == PMCMD_OP_MARGIN_LO);
    end

    // Digital regulator: issue OPERATION with the chosen margin
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pmbus_req        <= 1'b0;
            o_pmbus_chan       <= 6'h00;
            o_pmbus_cmd        <= PMCMD_PMBUS_OPERATION;
            o_pmbus_margin_low <= 1'b0;
        end
        else
        begin
            o_pmbus_req <= margin_go && i_digital_regulator_channel[chan_idx];
            if (margin_go && i_digital_regulator_channel[chan_idx])
            begin
                o_pmbus_chan       <= chan_idx;
                o_pmbus_cmd        <= PMCMD_PMBUS_OPERATION;
                o_pmbus_margin_low <= (opcode_reg == PMCMD_OP_MARGIN_LO);
            end
        end
    end

    // Step timer for the closed-loop trim
    logic [15:0] step_cnt_reg;
    logic        step_tick;
    assign step_tick = (step_cnt_reg == 16'h0000);
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            step_cnt_reg <= 16'h0000;
        else if (step_tick)
            step_cnt_reg <= 16'(STEP_CYC - 1);
        else
            step_cnt_reg <= step_cnt_reg - 16'h0001;
    end

    // Analog regulator trim: direct load or servo towards a target
    logic             analog_go;
    logic [ADC_W-1:0] target_reg;
    logic [DAC_W-1:0] dac_max;
    assign analog_go = margin_go && !i_digital_regulator_channel[chan_idx];
    assign dac_max   = '1;
    always_ff @(posedge i_mclk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_trim_chan <= 6'h00;
            o_trim_dac  <= '0;
            o_trim_load <= 1'b0;
            o_trim_busy <= 1'b0;
            target_reg  <= '0;
        end
        else
        begin
            o_trim_load <= 1'b0;
            if (analog_go)
            begin
                o_trim_chan <= chan_idx;
                if (i_closed_loop[chan_idx])
                begin
                    // Closed loop: servo starts from the current trim value
                    o_trim_busy <= 1'b1;
                    target_reg  <= (opcode_reg == PMCMD_OP_MARGIN_LO) ?
                        i_low_trim_target : i_nominal_voltage_target;
                end
                else
                begin
                    o_trim_busy <= 1'b0;
                    o_trim_load <= 1'b1;
                    o_trim_dac  <= (opcode_reg == PMCMD_OP_MARGIN_LO) ?
                        i_low_margin_dac_setting :
                        i_nominal_dac_setting;
                end
            end
            else if (o_trim_busy && step_tick)
            begin
                // Higher trim code raises the rail; stop on match or limit
                o_trim_load <= 1'b1;
                if (i_meas_voltage < target_reg && o_trim_dac != dac_max)
                    o_trim_dac <= o_trim_dac + 1'b1;
                else if (i_meas_voltage > target_reg && o_trim_dac != '0)
                    o_trim_dac <= o_trim_dac - 1'b1;
                else
                begin
                    o_trim_load <= 1'b0;
                    o_trim_busy <= 1'b0;
                end
            end
        end
    end

endmodule

// file: tb/pmcmd_port_sva.sv
// Assertions on the command port outputs, bound into the port
module pmcmd_port_sva
    import pmcmd_pkg::*;
#(
    parameter int DAC_W = 10
)(
    input wire logic             i_mclk,
    input wire logic             i_arst_n,
    input wire logic [1:0]       i_engine_state,
    input wire logic [63:0]      i_digital_regulator_channel,
    input wire logic [63:0]      i_closed_loop,
    input wire logic [DAC_W-1:0] i_low_margin_dac_setting,
    input wire logic [DAC_W-1:0] i_nominal_dac_setting,
    input wire logic             o_power_on_req,
    input wire logic             o_power_off_req,
    input wire logic [63:0]      o_margin_low,
    input wire logic [5:0]       o_trim_chan,
    input wire logic [DAC_W-1:0] o_trim_dac,
    input wire logic             o_trim_load,
    input wire logic             o_trim_busy,
    input wire logic             o_pmbus_req,
    input wire logic [5:0]       o_pmbus_chan,
    input wire logic [7:0]       o_pmbus_cmd,
    input wire logic             o_pmbus_margin_low
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    // Requests and margin changes only from the state that allows them
    property p_on_gate;
        o_power_on_req |-> $past(i_engine_state) == PMCMD_ENG_STOPPED
            || $past(i_engine_state, 2) == PMCMD_ENG_STOPPED;
    endproperty
    a_on_gate: assert property (p_on_gate)
        else $error("power-on request outside stopped state");
    property p_off_gate;
        o_power_off_req |-> $past(i_engine_state) == PMCMD_ENG_STARTED
            || $past(i_engine_state, 2) == PMCMD_ENG_STARTED;
    endproperty
    a_off_gate: assert property (p_off_gate)
        else $error("power-off request outside started state");
    property p_mlow_gate;
        $changed(o_margin_low) |-> $past(i_engine_state) == PMCMD_ENG_STARTED
            || $past(i_engine_state, 2) == PMCMD_ENG_STARTED;
    endproperty
    a_mlow_gate: assert property (p_mlow_gate)
        else $error("margin level changed outside started state");
    // One command touches one channel at most
    property p_one_chan;
        $countones(o_margin_low ^ $past(o_margin_low)) <= 1;
    endproperty
    a_one_chan: assert property (p_one_chan)
        else $error("margin levels of several channels changed at once");
    // Regulator bus request carries OPERATION and the channel's level
    property p_pmb_op;
        o_pmbus_req |-> o_pmbus_cmd == PMCMD_PMBUS_OPERATION
            && i_digital_regulator_channel[o_pmbus_chan];
    endproperty
    a_pmb_op: assert property (p_pmb_op)
        else $error("regulator request with wrong code or channel kind");
    property p_pmb_lvl;
        o_pmbus_req |-> o_pmbus_margin_low == o_margin_low[o_pmbus_chan];
    endproperty
    a_pmb_lvl: assert property (p_pmb_lvl)
        else $error("regulator request level differs from margin level");
    // Open-loop load applies the setting of the new level
    property p_open;
        o_trim_load && !o_trim_busy && !i_closed_loop[o_trim_chan] |->
            o_trim_dac == (o_margin_low[o_trim_chan] ?
            i_low_margin_dac_setting : i_nominal_dac_setting);
    endproperty
    a_open: assert property (p_open)
        else $error("open-loop trim value wrong for margin level");
    // Servo moves the trim value by one code per step
    property p_step;
        o_trim_load && o_trim_busy && $past(o_trim_busy)
            && $stable(o_trim_chan) |-> o_trim_dac == $past(o_trim_dac) + 1'b1
            || $past(o_trim_dac) == o_trim_dac + 1'b1;
    endproperty
    a_step: assert property (p_step)
        else $error("closed-loop trim step is not one code");
    c_on: cover property (o_power_on_req);
    c_pmb: cover property (o_pmbus_req);
    c_servo: cover property ($fell(o_trim_busy));
endmodule

bind pmcmd_port pmcmd_port_sva #(.DAC_W(DAC_W)) u_sva (
    .i_mclk, .i_arst_n, .i_engine_state, .i_digital_regulator_channel,
    .i_closed_loop, .i_low_margin_dac_setting, .i_nominal_dac_setting,
    .o_power_on_req, .o_power_off_req, .o_margin_low, .o_trim_chan,
    .o_trim_dac, .o_trim_load, .o_trim_busy, .o_pmbus_req, .o_pmbus_chan,
    .o_pmbus_cmd, .o_pmbus_margin_low
);

// file: tb/pmcmd_i2c_host.sv
// Behavioural I2C host that writes command transfers to the port
module pmcmd_i2c_host
#(
    parameter int HALF_NS = 40
)(
    input  wire logic i_sda_wire,
    output logic      o_scl,
    output logic      o_sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idles released, clock high, so the pull-up sets the level
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // One bit: data changes while the clock is low, sampled on its rise
    task automatic bit_io(input logic b, output logic s);
        o_sda_low = !b;
        #HALF_NS o_scl = 1'b1;
        s = i_sda_wire;
        #HALF_NS o_scl = 1'b0;
    endtask

    // Start, bytes MSB first with an ack slot each, then stop
    task automatic xfer(input logic [7:0] q[$], output int n);
        logic s;
        n = 0;
        o_sda_low = 1'b1;
        #HALF_NS o_scl = 1'b0;
        foreach (q[i])
        begin
            for (int k = 7; k >= 0; k--)
                bit_io(q[i][k], s);
            bit_io(1'b1, s);
            if (s === 1'b0 && n == i)
                n++;
        end
        o_sda_low = 1'b1;
        #HALF_NS o_scl = 1'b1;
        #HALF_NS o_sda_low = 1'b0;
        #HALF_NS;
    endtask
endmodule

// file: tb/pmcmd_port_tb_top.sv
// Self-checking bench for the power manager command port
module pmcmd_port_tb_top
    import pmcmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [6:0]  DEV     = 7'h10;
    localparam logic [15:0] ADR     = PMCMD_CMD_ADDR;
    localparam logic [7:0]  MLO     = PMCMD_OP_MARGIN_LO;
    localparam logic [7:0]  MNOM    = PMCMD_OP_MARGIN_NOMINAL_COMMAND;
    localparam logic [7:0]  OPR     = PMCMD_PMBUS_OPERATION;
    localparam logic [9:0]  LO_DAC  = 10'h0AA;
    localparam logic [9:0]  NOM_DAC = 10'h155;
    localparam logic [11:0] LO_TGT  = 12'h123;
    localparam logic [11:0] NOM_TGT = 12'h100;
    logic        mclk = 1'b0;
    logic        arst_n, scl, host_low, sda_w, sda_o, sda_oe;
    logic        on_req, off_req, load, busy, pmb_req, pmb_lo;
    logic [1:0]  eng;
    logic [63:0] dig, cl, mlow, m_before;
    logic [5:0]  tchan, pchan;
    logic [9:0]  tdac;
    logic [7:0]  pcmd;
    int          on_cnt, off_cnt, ld_cnt, pm_cnt, fail_count, checks;

    // Clock and open-drain data wire with pull-up
    always #2.5 mclk = ~mclk;
    assign sda_w = !(host_low || (sda_oe && !sda_o));

    // Port under test; measured voltage follows the trim code
    pmcmd_port #(.DEV_ADDR(DEV), .STEP_CYC(4)) dut (
        .i_mclk(mclk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda_w),
        .o_sda(sda_o), .o_sda_oe(sda_oe), .i_engine_state(eng),
        .i_digital_regulator_channel(dig), .i_closed_loop(cl),
        .i_low_margin_dac_setting(LO_DAC),
        .i_nominal_dac_setting(NOM_DAC), .i_low_trim_target(LO_TGT),
        .i_nominal_voltage_target(NOM_TGT), .i_meas_voltage({2'h0, tdac}),
        .o_power_on_req(on_req), .o_power_off_req(off_req),
        .o_margin_low(mlow), .o_trim_chan(tchan), .o_trim_dac(tdac),
        .o_trim_load(load), .o_trim_busy(busy), .o_pmbus_req(pmb_req),
        .o_pmbus_chan(pchan), .o_pmbus_cmd(pcmd), .o_pmbus_margin_low(pmb_lo)
    );
    pmcmd_i2c_host host (
        .i_sda_wire(sda_w), .o_scl(scl), .o_sda_low(host_low)
    );

    // Pulse counters, cleared at the start of each transfer
    always @(posedge mclk)
    begin
        on_cnt += int'(on_req);
        off_cnt += int'(off_req);
        ld_cnt += int'(load);
        pm_cnt += int'(pmb_req);
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic set_state(input logic [1:0] s);
        @(posedge mclk);
        #1 eng = s;
    endtask

    // One command transfer, then the ack count is compared
    task automatic cmd(input logic rd, input logic [15:0] a,
                       input logic [7:0] op, input int np,
                       input logic [7:0] ch);
        logic [7:0] q[$];
        int         n;
        q = '{{DEV, rd}, a[15:8], a[7:0], op};
        for (int i = 0; i < np; i++)
            q.push_back(i == 0 ? ch : 8'h5A);
        m_before = mlow;
        {on_cnt, off_cnt, ld_cnt, pm_cnt} = 128'h0;
        // Keep every pin change clear of the sampling edge
        @(posedge mclk);
        #1;
        host.xfer(q, n);
        repeat (20) @(posedge mclk);
        check(64'(n), rd ? 64'h0 : 64'(4 + (np > 63 ? 63 : np)));
    endtask

    // Refused command: no pulse and no margin change
    task automatic refuse(input logic rd, input logic [15:0] a,
                          input logic [7:0] op, input int np,
                          input logic [7:0] ch);
        cmd(rd, a, op, np, ch);
        check(mlow, m_before);
        check(64'(on_cnt + off_cnt + ld_cnt + pm_cnt), 64'h0);
    endtask

    // Closed-loop margin on channel 6, servo must settle on target
    task automatic servo(input logic [7:0] op, input logic [9:0] exp);
        int k;
        cmd(1'b0, ADR, op, 1, 8'h06);
        k = 0;
        while (busy !== 1'b0 && k < 5000)
        begin
            @(posedge mclk);
            k++;
        end
        check(64'({busy, tchan, tdac}), 64'({1'b0, 6'h5, exp}));
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main test sequence
    initial
    begin
        arst_n = 1'b0;
        eng = PMCMD_ENG_STOPPED;
        dig = 64'h8000_0000_0000_0000;
        cl = 64'h20;
        repeat (12) @(posedge mclk);
        #1 arst_n = 1'b1;
        repeat (5) @(posedge mclk);
        for (int s = 0; s < 4; s++)
        begin
            set_state(2'(s));
            cmd(1'b0, ADR, PMCMD_OP_POWER_ON, 0, 8'h00);
            check(64'(on_cnt), 64'(s == 0));
            cmd(1'b0, ADR, PMCMD_OP_POWER_OFF, 0, 8'h00);
            check(64'(off_cnt), 64'(s == 2));
        end
        $display("test power gating done");
        set_state(PMCMD_ENG_STOPPED);
        cmd(1'b0, ADR, MLO, 1, 8'h05);
        check(mlow, 64'h0);
        set_state(PMCMD_ENG_STARTED);
        cmd(1'b0, ADR, MLO, 1, 8'h05);
        check(mlow, 64'h10);
        check(64'({ld_cnt[3:0], tchan, tdac}), 64'({4'h1, 6'h4, LO_DAC}));
        cmd(1'b0, ADR, MNOM, 1, 8'h05);
        check(mlow, 64'h0);
        check(64'({tchan, tdac}), 64'({6'h4, NOM_DAC}));
        $display("test open-loop margin done");
        cmd(1'b0, ADR, MLO, 1, 8'h40);
        check(mlow, 64'h8000_0000_0000_0000);
        check(64'({pm_cnt[3:0], pchan, pcmd, pmb_lo}), 64'({4'h1, 6'h3F, OPR, 1'b1}));
        cmd(1'b0, ADR, MNOM, 1, 8'h40);
        check(mlow, 64'h0);
        check(64'({pchan, pcmd, pmb_lo}), 64'({6'h3F, OPR, 1'b0}));
        servo(MLO, LO_TGT[9:0]);
        check(mlow, 64'h20);
        servo(MNOM, NOM_TGT[9:0]);
        $display("test digital and closed-loop margin done");
        refuse(1'b0, 16'h8001, MLO, 1, 8'h01);
        refuse(1'b0, 16'hFFFF, MLO, 1, 8'h01);
        refuse(1'b1, ADR, MLO, 1, 8'h01);
        refuse(1'b0, ADR, PMCMD_OP_RESERVED, 1, 8'h01);
        refuse(1'b0, ADR, 8'h05, 1, 8'h01);
        refuse(1'b0, ADR, 8'hFF, 0, 8'h00);
        refuse(1'b0, ADR, MLO, 1, 8'h00);
        refuse(1'b0, ADR, MLO, 1, 8'h41);
        refuse(1'b0, ADR, MLO, 0, 8'h00);
        refuse(1'b0, ADR, MLO, 64, 8'h01);
        cmd(1'b0, ADR, MLO, 63, 8'h01);
        check(mlow, 64'h1);
        $display("test refusals done");
        conclude();
    end

    // Watchdog well past the expected run time
    initial
    begin
        #400_000;
        fail_count++;
        conclude();
    end
endmodule
